/* design/pio_top.sv */
// Programmable I/O port block: eleven eight-line ports with register port
//
// Behaviour
// - 87 I/O lines in ports zero to ten
// - Each I/O line has its own direction bit
// - Pull-ups selected per group of four lines
// - Interrupt line input-only, reads interrupt pin level
// - No direction bit for the interrupt line
// - Peripheral output drives pin despite direction bit
// - Direction bits map one to one to lines
// - Bus mode locks direction of bus pins
// - Bus mode locks data latch of bus pins
// - Input read gives pin; write updates latch
// - Output read gives latch contents
// - Output mode drives latch value onto pin
// - Direction 0 is input, 1 is output
// - Pull-up only while line is input
// - Latch-read bit forces port one latch read
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

module pio_top #(
  parameter int NUM_PORTS = `PIO_NUM_PORTS, // Number of eight-line ports
  parameter int NMI_PORT = `PIO_NMI_PORT, // Port holding the input-only line
  parameter int NMI_BIT = `PIO_NMI_BIT // Bit of the input-only line
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,

  // Register port
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [`PIO_SEL_W-1:0] reg_sel_i,
  input wire logic [`PIO_IDX_W-1:0] reg_idx_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_err_o,

  // Port control and mode
  input wire logic latch_read_select_bit_i,
  input wire logic bus_mode_i,
  input wire logic [NUM_PORTS*8-1:0] bus_ctrl_pin_i,

  // Peripheral functions
  input wire logic [NUM_PORTS*8-1:0] periph_oe_i,
  input wire logic [NUM_PORTS*8-1:0] periph_out_i,

  // Pins
  input wire logic [NUM_PORTS*8-1:0] pin_i,
  input wire logic input_only_interrupt_line_i,
  output logic [NUM_PORTS*8-1:0] pin_o,
  output logic [NUM_PORTS*8-1:0] pin_oe_o,
  output logic [NUM_PORTS*8-1:0] pin_pullup_o
);

  localparam int LINES = NUM_PORTS * 8; // All line positions, input-only included

  // Register port hit test for one port index
  function automatic logic pio_hit(input logic [`PIO_IDX_W-1:0] idx, input int port);
    pio_hit = (idx == port[`PIO_IDX_W-1:0]);
  endfunction

  // Selector decode into the shared kind type
  function automatic pio_pkg::pio_sel_type pio_kind(input logic [`PIO_SEL_W-1:0] sel);
    pio_kind = pio_pkg::pio_sel_type'(sel);
  endfunction

  pio_pkg::pio_sel_type sel_kind; // Decoded selector
  logic idx_ok; // Index names an existing port
  logic acc_ok; // Access names an existing register
  logic [7:0] rd_mux; // Read value before capture
  logic [7:0] reg_rdata_r; // Captured read data
  logic reg_rvalid_r; // Read answer pulse
  logic reg_err_r; // Unmapped access pulse
  logic [1:0] pullup_group_control_r [NUM_PORTS]; // Pull-up group selects per port
  logic [LINES-1:0] dir_all; // Direction bits of all ports
  logic [LINES-1:0] pin_sampled; // Pin levels with the interrupt line merged
  logic [LINES-1:0] nmi_mask; // Position of the input-only line
  logic [LINES-1:0] pu_group; // Group select spread onto lines
  logic [LINES-1:0] lock_all; // Bus-control lines locked in bus mode
  logic [7:0] bank_dir [NUM_PORTS]; // Per-port direction read values
  logic [7:0] bank_rd [NUM_PORTS]; // Per-port data read values

  // Selector and index checks
  assign sel_kind = pio_kind(reg_sel_i);
  assign idx_ok = (reg_idx_i < NUM_PORTS[`PIO_IDX_W-1:0]);
  assign acc_ok = idx_ok && (sel_kind != pio_pkg::PIO_SEL_NONE);

  // Lines that act as bus control while the device runs with an external bus
  assign lock_all = bus_mode_i ? bus_ctrl_pin_i : '0;

  // Input-only line position
  always_comb begin
    nmi_mask = '0;
    nmi_mask[NMI_PORT*8+NMI_BIT] = 1'b1;
  end

  // Interrupt pin level replaces the plain pin sample on the input-only line
  assign pin_sampled = (pin_i & ~nmi_mask) | ({LINES{input_only_interrupt_line_i}} & nmi_mask);

  // One bank per port, each with its own carrier
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      pio_bank_if bif ();

      // Write strobes for this port
      assign bif.we_dir = reg_we_i && pio_hit(reg_idx_i, p) && (sel_kind == pio_pkg::PIO_SEL_DIR);
      assign bif.we_data = reg_we_i && pio_hit(reg_idx_i, p) && (sel_kind == pio_pkg::PIO_SEL_DATA);
      assign bif.wdata = reg_wdata_i;
      assign bif.lock = lock_all[p*8 +: 8];

      // Only port one honours the latch-read select
      assign bif.latch_rd = (p == `PIO_LATCH_RD_PORT) ? latch_read_select_bit_i : 1'b0;
      assign bif.pin_in = pin_sampled[p*8 +: 8];
      assign bif.periph_oe = periph_oe_i[p*8 +: 8];
      assign bif.periph_out = periph_out_i[p*8 +: 8];

      // Bank collects results into the flat vectors
      assign dir_all[p*8 +: 8] = bif.dir;
      assign bank_dir[p] = bif.dir;
      assign bank_rd[p] = bif.rd_val;
      assign pin_o[p*8 +: 8] = bif.pin_out;
      assign pin_oe_o[p*8 +: 8] = bif.pin_oe;

      // Group selects spread onto four lines each
      assign pu_group[p*8 +: 4] = {4{pullup_group_control_r[p][0]}};
      assign pu_group[p*8+4 +: 4] = {4{pullup_group_control_r[p][1]}};

      // Port bank instance, the interrupt port has one input-only line
      pio_line_bank #(
        .INPUT_ONLY_MASK((p == NMI_PORT) ? `PIO_NMI_MASK : 8'h00)
      ) u_bank (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .bk(bif.bank)
      );
    end
  endgenerate

  // Pull-up group registers, one pair of group bits per port
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        pullup_group_control_r[i] <= `PIO_PU_RST;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        // Contents may change even while bus mode holds pull-ups off
        if (reg_we_i && pio_hit(reg_idx_i, i) && (sel_kind == pio_pkg::PIO_SEL_PULLUP)) begin
          pullup_group_control_r[i] <= reg_wdata_i[1:0];
        end
      end
    end
  end

  // Pull-up only on input lines not driven, never on bus pins or the interrupt line
  assign pin_pullup_o = pu_group & ~dir_all & ~periph_oe_i & ~lock_all & ~nmi_mask;

  // Read selection for the addressed register
  always_comb begin
    rd_mux = `PIO_RDATA_RST;
    if (!idx_ok) begin
      rd_mux = `PIO_RDATA_RST;
    end else if (sel_kind == pio_pkg::PIO_SEL_DIR) begin
      rd_mux = bank_dir[reg_idx_i];
    end else if (sel_kind == pio_pkg::PIO_SEL_DATA) begin
      rd_mux = bank_rd[reg_idx_i];
    end else if (sel_kind == pio_pkg::PIO_SEL_PULLUP) begin
      rd_mux = {6'h00, pullup_group_control_r[reg_idx_i]};
    end else begin
      rd_mux = `PIO_RDATA_RST;
    end
  end

  // Read data capture, held until the next read
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_r <= `PIO_RDATA_RST;
    end else if (reg_re_i) begin
      reg_rdata_r <= rd_mux;
    end
  end

  // Read answer pulse one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_re_i;
    end
  end

  // Error pulse for an access to no register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      reg_err_r <= 1'b0;
    end else begin
      reg_err_r <= (reg_re_i || reg_we_i) && !acc_ok;
    end
  end

  // Register port outputs
  assign reg_rdata_o = reg_rdata_r;
  assign reg_rvalid_o = reg_rvalid_r;
  assign reg_err_o = reg_err_r;

endmodule

`default_nettype wire

/* pkg/pio_defs.svh */
// Constants for the programmable I/O port block: sizes, positions, reset values
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// Number of ports and lines per port
`define PIO_NUM_PORTS 11
`define PIO_PORT_W 8
`define PIO_ALL_LINES 88
`define PIO_IO_LINES 87

// Width of the register port index and selector
`define PIO_IDX_W 4
`define PIO_SEL_W 2

// Pull-up grouping: lines per group, groups per port
`define PIO_GRP_LINES 4
`define PIO_GRPS_PER_PORT 2

// Position of the input-only interrupt line
`define PIO_NMI_PORT 8
`define PIO_NMI_BIT 5
`define PIO_NMI_MASK 8'h20

// Port whose data read can be forced to the latch
`define PIO_LATCH_RD_PORT 1

// Reset values
`define PIO_DIR_RST 8'h00
`define PIO_DATA_RST 8'h00
`define PIO_PU_RST 2'h0
`define PIO_RDATA_RST 8'h00

`endif

/* pkg/pio_pkg.sv */
// Types shared by the programmable I/O port block
package pio_pkg;

  // Register kind selector on the register port
  typedef enum logic [1:0] {
    PIO_SEL_DIR = 2'b00,
    PIO_SEL_DATA = 2'b01,
    PIO_SEL_PULLUP = 2'b10,
    PIO_SEL_NONE = 2'b11
  } pio_sel_type;

  // One port's worth of line bits
  typedef logic [7:0] pio_byte_type;

endpackage

/* pkg/pio_bank_if.sv */
// Carrier between the port top and one eight-line port bank
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

interface pio_bank_if;
  logic we_dir; // Write strobe, direction register
  logic we_data; // Write strobe, data register
  pio_pkg::pio_byte_type wdata; // Write data
  pio_pkg::pio_byte_type lock; // Lines locked by bus mode
  logic latch_rd; // Force data reads to the latch
  pio_pkg::pio_byte_type pin_in; // Sampled pin levels
  pio_pkg::pio_byte_type periph_oe; // Peripheral drives line
  pio_pkg::pio_byte_type periph_out; // Peripheral output value
  pio_pkg::pio_byte_type dir; // Direction bits
  pio_pkg::pio_byte_type rd_val; // Data register read value
  pio_pkg::pio_byte_type pin_out; // Pin output value
  pio_pkg::pio_byte_type pin_oe; // Pin output enable

  // Control side
  modport ctrl (
    output we_dir, we_data, wdata, lock, latch_rd, pin_in, periph_oe, periph_out,
    input dir, rd_val, pin_out, pin_oe
  );

  // Bank side
  modport bank (
    input we_dir, we_data, wdata, lock, latch_rd, pin_in, periph_oe, periph_out,
    output dir, rd_val, pin_out, pin_oe
  );
endinterface

`default_nettype wire

/* design/pio_line_bank.sv */
// Eight-line port bank: direction bits, port latch, read path and pin drive
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

module pio_line_bank #(
  parameter logic [7:0] INPUT_ONLY_MASK = 8'h00 // Lines with no direction bit
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Carrier to the top
  pio_bank_if.bank bk
);

  logic [7:0] dir_r; // Direction bits, 1 is output
  logic [7:0] dir_nxt; // Next direction bits
  logic [7:0] latch_r; // Port latch
  logic [7:0] latch_nxt; // Next port latch
  logic [7:0] out_mode; // Lines in output mode

  // Locked bits keep their value, the rest take the write; no bit for input-only lines
  always_comb begin
    dir_nxt = dir_r;
    latch_nxt = latch_r;
    if (bk.we_dir) begin
      dir_nxt = ((dir_r & bk.lock) | (bk.wdata & ~bk.lock)) & ~INPUT_ONLY_MASK;
    end
    if (bk.we_data) begin
      latch_nxt = (latch_r & bk.lock) | (bk.wdata & ~bk.lock);
    end
  end

  // Direction register, all inputs after reset
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dir_r <= `PIO_DIR_RST;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // Port latch, written in either mode
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      latch_r <= `PIO_DATA_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // A set direction bit selects output mode
  assign out_mode = dir_r & ~INPUT_ONLY_MASK;

  // Read path: pin level for inputs, latch for outputs or when forced
  assign bk.rd_val = bk.latch_rd ? latch_r : ((latch_r & out_mode) | (bk.pin_in & ~out_mode));

  // Pin drive: peripheral output overrides the direction bit
  assign bk.pin_oe = (out_mode | bk.periph_oe) & ~INPUT_ONLY_MASK;
  assign bk.pin_out = ((bk.periph_oe & bk.periph_out) | (~bk.periph_oe & latch_r)) & ~INPUT_ONLY_MASK;
  assign bk.dir = dir_r;

endmodule

`default_nettype wire

/* dv/pio_properties.sv */
// Checker on the port block's top-level pins, bound to pio_top
`timescale 1ns/1ps
`default_nettype none

module pio_properties #(
  parameter int NUM_PORTS = 11,
  parameter int NMI_PORT = 8,
  parameter int NMI_BIT = 5
) (
  // Clock, reset, register port
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [3:0] reg_idx_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_err_o,
  // Mode, peripherals and pins
  input wire logic bus_mode_i,
  input wire logic [NUM_PORTS*8-1:0] bus_ctrl_pin_i,
  input wire logic [NUM_PORTS*8-1:0] periph_oe_i,
  input wire logic [NUM_PORTS*8-1:0] periph_out_i,
  input wire logic input_only_interrupt_line_i,
  input wire logic [NUM_PORTS*8-1:0] pin_o,
  input wire logic [NUM_PORTS*8-1:0] pin_oe_o,
  input wire logic [NUM_PORTS*8-1:0] pin_pullup_o
);
  // Position of the input-only line
  // Built at full width so the shift cannot run off a 32-bit literal
  localparam logic [NUM_PORTS*8-1:0] NMI_M = {{(NUM_PORTS*8-1){1'b0}}, 1'b1} << (NMI_PORT*8+NMI_BIT);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_nmi_no_drive; (pin_oe_o & NMI_M) == '0; endproperty
  a_nmi_no_drive: assert property (p_nmi_no_drive) else $error("input-only line driven");
  property p_periph; ((pin_oe_o & periph_oe_i) == (periph_oe_i & ~NMI_M))
    && (((pin_o ^ periph_out_i) & periph_oe_i & ~NMI_M) == '0); endproperty
  a_periph: assert property (p_periph) else $error("peripheral output not on pin");
  property p_pullup_in; (pin_pullup_o & (pin_oe_o | NMI_M)) == '0; endproperty
  a_pullup_in: assert property (p_pullup_in) else $error("pull-up on driven line");
  property p_rvalid; reg_re_i && reg_idx_i <= 4'hA && reg_sel_i != 2'h3 |=> reg_rvalid_o && !reg_err_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_err; (reg_we_i || reg_re_i) && (reg_idx_i > 4'hA || reg_sel_i == 2'h3) |=> reg_err_o; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_rst; $rose(nrst_i) |-> (pin_oe_o & ~periph_oe_i) == '0; endproperty
  a_rst: assert property (p_rst) else $error("line output after reset");
  property p_dir_wr; reg_we_i && reg_sel_i == 2'h0 && reg_idx_i == 4'h2 && !bus_mode_i
    |=> pin_oe_o[23:16] == ($past(reg_wdata_i) | periph_oe_i[23:16]); endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write not applied");
  property p_nmi_rd; reg_re_i && reg_sel_i == 2'h1 && reg_idx_i == 4'h8
    |=> reg_rdata_o[5] == $past(input_only_interrupt_line_i); endproperty
  a_nmi_rd: assert property (p_nmi_rd) else $error("interrupt level not read");
  property p_lock; bus_mode_i && reg_we_i && reg_sel_i == 2'h0 |=> ((pin_oe_o ^ $past(pin_oe_o))
    & $past(bus_ctrl_pin_i) & ~periph_oe_i & ~$past(periph_oe_i)) == '0; endproperty
  a_lock: assert property (p_lock) else $error("locked direction changed");
endmodule

bind pio_top pio_properties #(.NUM_PORTS(NUM_PORTS), .NMI_PORT(NMI_PORT), .NMI_BIT(NMI_BIT)) chk (.*);

`default_nettype wire

/* dv/pio_ext_model.sv */
// External devices on the pins: drive, pull-up or floating level
`timescale 1ns/1ps
`default_nettype none

module pio_ext_model (
  // Clock
  input wire logic sys_clk_i,
  // Block side of each pin
  input wire logic [87:0] pin_o,
  input wire logic [87:0] pin_oe_o,
  input wire logic [87:0] pin_pullup_o,
  // Which lines the devices drive, and to what
  input wire logic [87:0] ext_en_i,
  input wire logic [87:0] ext_val_i,
  // Resolved wire level
  output logic [87:0] pin_i
);
  logic [87:0] float_r; // Changing pattern for undriven lines
  // Floating lines never hold a steady value
  always @(posedge sys_clk_i) begin
    float_r <= ~float_r;
  end
  initial float_r = 88'h0;
  // Block drive wins, then devices, then pull-up
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ((ext_en_i & ext_val_i)
    | (~ext_en_i & (pin_pullup_o | float_r))));
endmodule

`default_nettype wire

/* dv/programmable_io_ports_test.sv */
// Self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none

module programmable_io_ports_test;
  typedef struct packed {logic [3:0] idx; logic [7:0] dir, lat, pinv; logic nmi;} pio_row_type;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_we_i = 1'b0, reg_re_i = 1'b0, latch_sel = 1'b0, bus_mode_i = 1'b0, nmi = 1'b0;
  logic [1:0] reg_sel_i = 2'h0;
  logic [3:0] reg_idx_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d, e;
  logic reg_rvalid_o, reg_err_o;
  logic [87:0] bus_ctrl = '0, p_oe = '0, p_out = '0, ext_en = '1, ext_val = '0;
  logic [87:0] pin_i, pin_o, pin_oe_o, pin_pullup_o;
  int n_errors = 0, n_tests = 0, p;
  pio_row_type rows [4];
  pio_row_type r;

  always #5 sys_clk_i = ~sys_clk_i;

  pio_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_sel_i(reg_sel_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .reg_err_o(reg_err_o), .latch_read_select_bit_i(latch_sel),
    .bus_mode_i(bus_mode_i), .bus_ctrl_pin_i(bus_ctrl), .periph_oe_i(p_oe), .periph_out_i(p_out),
    .pin_i(pin_i), .input_only_interrupt_line_i(nmi), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o));
  pio_ext_model ext (.sys_clk_i(sys_clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i(pin_i));

  // Compare and count
  task automatic chk(input logic [87:0] got, input logic [87:0] exp);
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_errors++;
    end
    n_tests++;
  endtask
  // One register write, taken at the second edge
  task automatic wr(input logic [1:0] s, input logic [3:0] i, input logic [7:0] w);
    @(posedge sys_clk_i);
    reg_we_i <= 1'b1; reg_sel_i <= s; reg_idx_i <= i; reg_wdata_i <= w;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask
  // One register read, answer checked one cycle later
  task automatic rd(input logic [1:0] s, input logic [3:0] i, input logic [7:0] x);
    @(posedge sys_clk_i);
    reg_re_i <= 1'b1; reg_sel_i <= s; reg_idx_i <= i;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1 chk({reg_rvalid_o, reg_rdata_o}, {1'b1, x});
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000 n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rows = '{'{4'h0, 8'hFF, 8'h3C, 8'h00, 1'b0}, '{4'h2, 8'h0F, 8'hA5, 8'h5A, 1'b0},
      '{4'h8, 8'hFF, 8'h81, 8'h7E, 1'b1}, '{4'hA, 8'h00, 8'hFF, 8'hC3, 1'b0}};
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1 chk(pin_oe_o, 88'h0);
    // Table rows: direction, latch, pin level, read path
    foreach (rows[k]) begin
      r = rows[k];
      p = r.idx;
      wr(2'h0, r.idx, r.dir);
      wr(2'h1, r.idx, r.lat);
      ext_val[p*8+:8] <= r.pinv;
      nmi <= r.nmi;
      d = (p == 8) ? (r.dir & 8'hDF) : r.dir;
      e = (r.lat & d) | (r.pinv & ~d);
      if (p == 8) e[5] = r.nmi;
      rd(2'h1, r.idx, e);
      rd(2'h0, r.idx, d);
      chk({pin_oe_o[p*8+:8], pin_o[p*8+:8] & d}, {d, r.lat & d});
    end
    // Latch-read select on port one
    wr(2'h0, 4'h1, 8'h00);
    wr(2'h1, 4'h1, 8'h5A);
    ext_val[15:8] <= 8'hA5;
    latch_sel <= 1'b1;
    rd(2'h1, 4'h1, 8'h5A);
    latch_sel <= 1'b0;
    // Pull-up groups of four, input lines only
    ext_en[31:24] <= 8'h00;
    wr(2'h2, 4'h3, 8'h01);
    #1 chk(pin_pullup_o[31:24], 8'h0F);
    rd(2'h2, 4'h3, 8'h01);
    wr(2'h0, 4'h3, 8'h01);
    #1 chk(pin_pullup_o[31:24], 8'h0E);
    // Peripheral output overrides an input direction
    p_oe[32] <= 1'b1;
    p_out[32] <= 1'b1;
    wr(2'h0, 4'h4, 8'h00);
    #1 chk({pin_oe_o[32], pin_o[32]}, 2'b11);
    // Bus mode locks control lines
    wr(2'h0, 4'h2, 8'h00);
    wr(2'h1, 4'h2, 8'h00);
    bus_mode_i <= 1'b1;
    bus_ctrl[23:16] <= 8'hF0;
    wr(2'h0, 4'h2, 8'hFF);
    wr(2'h1, 4'h2, 8'hFF);
    #1 chk({pin_oe_o[23:16], pin_o[23:16]}, 16'h0F0F);
    bus_mode_i <= 1'b0;
    // Unmapped index and selector are refused
    wr(2'h0, 4'hB, 8'hFF);
    #1 chk({reg_err_o, pin_oe_o[23:16]}, 9'h10F);
    wr(2'h3, 4'h0, 8'hFF);
    #1 chk(reg_err_o, 1'b1);
    // A refused read still answers, with zero data and the error pulse
    rd(2'h1, 4'hB, 8'h00);
    chk(reg_err_o, 1'b1);
    // Reset in mid-run clears directions
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1 chk(pin_oe_o, p_oe);
    tally_and_finish();
  end
endmodule

`default_nettype wire
